// file: rtl/tcep_line_rx.sv
// Line receiver: samples the line clock, aligns bits and delivers octets.
`timescale 1ns/1ps
module tcep_line_rx
  import tcep_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic line_clk,
  input  wire logic line_data,
  input  wire logic line_sync,
  tcep_oct_if.rx    oi
);
  typedef struct packed {
    logic [2:0] clk_s;
    logic [1:0] dat_s;
    logic [1:0] syn_s;
    logic [7:0] pos;
    logic [7:0] sh;
    logic [2:0] ubit;
    logic       valid;
    logic [7:0] data;
    logic [4:0] slot;
    logic       last;
  } tcep_rx_st_t;

  tcep_rx_st_t s_q, s_d;
  logic [7:0]  bitp;
  logic [7:0]  idx;
  logic [7:0]  sh_n;

  always_comb begin
    s_d       = s_q;
    s_d.clk_s = {s_q.clk_s[1:0], line_clk};
    s_d.dat_s = {s_q.dat_s[0], line_data};
    s_d.syn_s = {s_q.syn_s[0], line_sync};
    s_d.valid = 1'b0;
    bitp      = s_q.syn_s[1] ? 8'h00 : 8'(s_q.pos + 8'h01);
    idx       = 8'(bitp - {7'h00, oi.ds1});
    sh_n      = {s_q.sh[6:0], s_q.dat_s[1]};
    if (s_q.clk_s[1] && !s_q.clk_s[2]) begin
      s_d.pos  = bitp;
      s_d.sh   = sh_n;
      s_d.ubit = 3'(s_q.ubit + 3'h1);
      if (oi.unstr) begin
        // Framing bit is packed like any other bit.
        if (s_q.ubit == 3'h7) begin
          s_d.valid = 1'b1;
          s_d.data  = sh_n;
          s_d.slot  = 5'h00;
          s_d.last  = 1'b0;
        end
      end else if ((bitp >= {7'h00, oi.ds1}) && (idx[2:0] == 3'h7)) begin
        // Framing bit of a DS1 frame is skipped; octets follow in slot order.
        s_d.valid = 1'b1;
        s_d.data  = sh_n;
        s_d.slot  = idx[7:3];
        s_d.last  = (idx[7:3] == (oi.ds1 ? DS1_LAST_SLOT : E1_LAST_SLOT));
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign oi.valid = s_q.valid;
  assign oi.data  = s_q.data;
  assign oi.slot  = s_q.slot;
  assign oi.last  = s_q.last;

  AST_RX_SPACING: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_q.valid |=> !s_q.valid [*8])
    else $error("Octets delivered closer than eight cycles.");
  AST_RX_DS1_SLOT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.valid && oi.ds1 && !oi.unstr) |-> (s_q.slot <= DS1_LAST_SLOT))
    else $error("DS1 octet slot out of range.");
endmodule : tcep_line_rx

// file: rtl/tcep_packetizer.sv
// Circuit emulation packetizer: TDM line octets into pseudowire payloads.
`timescale 1ns/1ps
// Function
// - Each circuit is carried as a pseudowire payload, unstructured or structure-aware.
// - In structured mode each frame adds one octet per selected slot, frames in arrival order.
// - Selected slots may be any subset of the frame other than E1 slot 0 and need not be adjacent.
// - With E1 CAS the frames per packet are fixed at 16 and not configurable.
// - The configured size with CAS counts only slot octets, not signalling octets.
// - In unstructured mode the group holds every slot, 24 for DS1 or 32 for E1.
// - Unstructured payload size is accepted only from 2 to 1514 octets.
// - Unstructured DS1 carries the 193rd framing bit inside the payload.
// - Unstructured default payload is 192 octets for DS1 and 256 for E1.
// - A structured group holds 1 to 24 slots on DS1 and 1 to 31 on E1.
// - Structured size is a multiple of the slot count, from 2 to 1514 octets.
// - Each of the 16 ports is configured independently of the others.
// - E1 CAS nibbles come from slot 16 over a 16-frame multiframe for channels 1 to 15 and 17 to 31.
module tcep_packetizer
  import tcep_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                line_clk,
  input  wire logic                line_data,
  input  wire logic                line_sync,
  input  wire logic                port_en,
  input  wire tcep_circuit_t       circuit_type_setting,
  input  wire logic                cas_en,
  input  wire logic [31:0]         slot_mask,
  input  wire logic [SIZE_W-1:0]   pay_size,
  output logic                     pkt_valid,
  output logic                     pkt_sop,
  output logic                     pkt_eop,
  output logic [7:0]               pkt_data,
  output logic                     cfg_err,
  output logic [5:0]               grp_count
);
  typedef struct packed {
    tcep_state_t       st;
    logic [SIZE_W-1:0] cnt;
    logic [SIZE_W-1:0] seen;
    logic [4:0]        scan;
    logic [3:0]        hold;
    logic              hold_v;
    logic [31:0][3:0]  nib;
    logic [3:0]        mf;
    logic              cfg_err;
    logic [5:0]        grp;
    logic              pval;
    logic              psop;
    logic              peop;
    logic [7:0]        pdat;
  } tcep_pk_st_t;

  tcep_oct_if oi ();

  tcep_line_rx u_rx (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .line_clk  (line_clk),
    .line_data (line_data),
    .line_sync (line_sync),
    .oi        (oi)
  );

  function automatic logic [5:0] tcep_popcount(input logic [31:0] m);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 32; i++) begin
      c = 6'(c + {5'h00, m[i]});
    end
    return c;
  endfunction : tcep_popcount

  tcep_pk_st_t       s_q, s_d;
  logic              unstr, ds1, cas;
  logic [31:0]       grp_m;
  logic [5:0]        n;
  logic [SIZE_W-1:0] eff_size, target, ncas, total;
  logic              err;
  logic              last_sel;

  assign unstr = (circuit_type_setting == unstructured_ds1_type) ||
                 (circuit_type_setting == unstructured_e1_type);
  assign ds1   = (circuit_type_setting == unstructured_ds1_type) ||
                 (circuit_type_setting == structured_ds1_type);
  assign cas   = cas_en && !unstr && !ds1;
  assign oi.unstr = unstr;
  assign oi.ds1   = ds1;
  assign last_sel = ((grp_m >> s_q.scan) == 32'h0000_0001);

  always_comb begin
    // Each instance holds its own settings, so ports never interact.
    if (unstr) begin
      grp_m = ds1 ? DS1_MASK : E1_MASK;
    end else begin
      grp_m = slot_mask & (ds1 ? DS1_MASK : E1_FAS_CLEAR);
    end
    n = tcep_popcount(grp_m);
    if (pay_size == '0) begin
      eff_size = ds1 ? SIZE_W'(DS1_DEF_PAY) : SIZE_W'(E1_DEF_PAY);
    end else begin
      eff_size = pay_size;
    end
    ncas   = SIZE_W'((n + 6'h01) >> 1);
    target = cas ? SIZE_W'({n, 4'h0}) : eff_size;
    total  = cas ? SIZE_W'(target + ncas) : target;
    err    = (eff_size < SIZE_W'(PAY_MIN)) || (eff_size > SIZE_W'(PAY_MAX));
    if (!unstr) begin
      err = err || (n == 6'h00) ||
            (n > (ds1 ? 6'(DS1_MAX_GROUP) : 6'(E1_MAX_GROUP)));
      if (cas) begin
        err = err || ((pay_size != '0) && (pay_size != target));
      end else if (n != 6'h00) begin
        err = err || ((eff_size % SIZE_W'(n)) != '0);
      end
    end
  end

  always_comb begin
    s_d         = s_q;
    s_d.cfg_err = err;
    s_d.grp     = n;
    s_d.pval    = 1'b0;
    s_d.psop    = 1'b0;
    s_d.peop    = 1'b0;
    if (oi.valid && cas && (oi.slot == 5'(CAS_SLOT))) begin
      // Slot 16 carries two channels per frame; all-zero high nibble marks frame 0.
      if (oi.data[7:4] == 4'h0) begin
        s_d.mf = 4'h0;
      end else begin
        s_d.mf = 4'(s_q.mf + 4'h1);
        s_d.nib[s_d.mf]                = oi.data[7:4];
        s_d.nib[{1'b1, s_d.mf}]        = oi.data[3:0];
      end
    end
    case (s_q.st)
      st_idle: begin
        s_d.cnt  = '0;
        s_d.seen = '0;
        if (port_en && !s_q.cfg_err && !err) begin
          if (unstr) begin
            s_d.st = st_data;
          end else if (oi.valid && oi.last && (!cas || s_q.mf == MF_LAST)) begin
            s_d.st = st_data;
          end
        end
      end
      st_data: begin
        if (!port_en || err) begin
          s_d.st = st_idle;
        end else if (oi.valid && grp_m[oi.slot]) begin
          // Every selected octet goes out in arrival order.
          s_d.pval = 1'b1;
          s_d.pdat = oi.data;
          s_d.psop = (s_q.cnt == '0);
          s_d.cnt  = SIZE_W'(s_q.cnt + 1'b1);
          if (s_d.cnt == target) begin
            if (cas) begin
              s_d.st     = st_cas;
              s_d.scan   = 5'h00;
              s_d.hold_v = 1'b0;
            end else begin
              s_d.peop = 1'b1;
              s_d.cnt  = '0;
            end
          end
        end
      end
      st_cas: begin
        // Nibbles of the selected channels, two to an octet, pad if odd.
        s_d.scan = 5'(s_q.scan + 5'h01);
        if (grp_m[s_q.scan]) begin
          if (s_q.hold_v) begin
            s_d.pval   = 1'b1;
            s_d.pdat   = {s_q.hold, s_q.nib[s_q.scan]};
            s_d.hold_v = 1'b0;
          end else if (last_sel) begin
            s_d.pval = 1'b1;
            s_d.pdat = {s_q.nib[s_q.scan], CAS_PAD};
          end else begin
            s_d.hold   = s_q.nib[s_q.scan];
            s_d.hold_v = 1'b1;
          end
        end
        if (s_d.pval) begin
          s_d.cnt = SIZE_W'(s_q.cnt + 1'b1);
          if (last_sel) begin
            s_d.peop = 1'b1;
            s_d.cnt  = '0;
          end
        end
        if (s_q.scan == E1_LAST_SLOT) begin
          s_d.st = st_data;
        end
      end
      default: begin
        s_d.st = st_idle;
      end
    endcase
    if (s_d.pval) begin
      s_d.seen = s_d.psop ? '0 : SIZE_W'(s_q.seen + 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pkt_valid = s_q.pval;
  assign pkt_sop   = s_q.psop;
  assign pkt_eop   = s_q.peop;
  assign pkt_data  = s_q.pdat;
  assign cfg_err   = s_q.cfg_err;
  assign grp_count = s_q.grp;

  AST_PKT_LEN: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.pval && s_q.peop && !cas && $stable(eff_size)) |-> (SIZE_W'(s_q.seen + 1'b1) == target)
    ) else $error("Packet length differs from configured size.");
  AST_CAS_LEN: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.pval && s_q.peop && cas && $stable(n)) |-> (SIZE_W'(s_q.seen + 1'b1) == total))
    else $error("CAS packet length wrong.");
  AST_UNSTR_FULL: assert property (@(posedge core_clk) disable iff (!rst_b)
    (unstr && $stable(circuit_type_setting)) |=> (s_q.grp == ($past(ds1) ? 6'd24 : 6'd32)))
    else $error("Unstructured group not full.");
  AST_GROUP_RANGE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!unstr && (n == 6'h00 || n > (ds1 ? 6'd24 : 6'd31))) |=> s_q.cfg_err)
    else $error("Bad group size accepted.");
  AST_SIZE_RANGE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pay_size != '0 && (pay_size < 11'd2 || pay_size > 11'd1514)) |=> s_q.cfg_err)
    else $error("Bad payload size accepted.");
  AST_MULTIPLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!unstr && !cas && n != 6'h00 && (eff_size % SIZE_W'(n)) != '0) |=> s_q.cfg_err)
    else $error("Size not a multiple of group accepted.");
  AST_DEFAULT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (unstr && pay_size == '0) |-> (eff_size == (ds1 ? 11'd192 : 11'd256)))
    else $error("Wrong default payload size.");
  AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.st == st_idle) |=> !s_q.pval)
    else $error("Output while idle.");
  AST_CAS_TAIL: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.st == st_data && s_d.st == st_cas) |-> ##33 (s_q.st != st_cas))
    else $error("Signalling tail overran its scan.");
endmodule : tcep_packetizer

// file: shared/tcep_oct_if.sv
// Octet stream between the line receiver and the packer.
`timescale 1ns/1ps
interface tcep_oct_if;
  logic       unstr;
  logic       ds1;
  logic       valid;
  logic [7:0] data;
  logic [4:0] slot;
  logic       last;
  modport rx (input unstr, input ds1, output valid, output data, output slot, output last);
  modport pk (output unstr, output ds1, input valid, input data, input slot, input last);
endinterface : tcep_oct_if

// file: shared/tcep_pkg.sv
// Constants and types shared by the circuit emulation packetizer.
package tcep_pkg;
  localparam int          DS1_SLOTS      = 24;
  localparam int          E1_SLOTS       = 32;
  localparam int          DS1_FRAME_BITS = 193;
  localparam int          DS1_MAX_GROUP  = 24;
  localparam int          E1_MAX_GROUP   = 31;
  localparam int          PAY_MIN        = 2;
  localparam int          PAY_MAX        = 1514;
  localparam int          DS1_DEF_PAY    = 192;
  localparam int          E1_DEF_PAY     = 256;
  localparam int          CAS_FRAMES     = 16;
  localparam int          CAS_SLOT       = 16;
  localparam logic [3:0]  MF_LAST        = 4'hf;
  localparam logic [4:0]  DS1_LAST_SLOT  = 5'h17;
  localparam logic [4:0]  E1_LAST_SLOT   = 5'h1f;
  localparam logic [31:0] DS1_MASK       = 32'h00ff_ffff;
  localparam logic [31:0] E1_MASK        = 32'hffff_ffff;
  localparam logic [31:0] E1_FAS_CLEAR   = 32'hffff_fffe;
  localparam logic [3:0]  CAS_PAD        = 4'h0;
  localparam int          SIZE_W         = 11;

  typedef enum logic [1:0] {
    unstructured_ds1_type,
    unstructured_e1_type,
    structured_ds1_type,
    structured_e1_type
  } tcep_circuit_t;

  typedef enum logic [1:0] {st_idle, st_data, st_cas} tcep_state_t;
endpackage : tcep_pkg

// file: verification/tcep_line_model.sv
// Behavioural TDM line transmitter that feeds framed bits to the packetizer.
`timescale 1ns/1ps
module tcep_line_model (
  input  wire logic ds1,
  input  wire logic fill,
  output logic      line_clk,
  output logic      line_data,
  output logic      line_sync
);
  logic [7:0] frm;
  logic [7:0] oct;
  logic       is_ds1;
  int         nbit;
  int         pos;

  // Octet of slot s in the current frame; E1 slot 16 carries the signalling nibbles.
  function automatic logic [7:0] slot_oct(input int s);
    if (fill) return 8'h00;
    if (!is_ds1 && s == 16) return (frm[3:0] == 4'h0) ? 8'h0b : {frm[3:0], ~frm[3:0]};
    return {frm[2:0], s[4:0]};
  endfunction : slot_oct

  // Data changes on the falling line edge; the packetizer samples on the rising one.
  initial begin
    line_clk  = 1'b0;
    line_data = 1'b0;
    line_sync = 1'b0;
    frm       = 8'h00;
    forever begin
      // A change of line format restarts the multiframe count at frame 0.
      if (ds1 !== is_ds1) frm = 8'h00;
      is_ds1 = ds1;
      nbit   = is_ds1 ? 193 : 256;
      for (int i = 0; i < nbit; i++) begin
        pos       = is_ds1 ? i - 1 : i;
        line_clk  = 1'b0;
        line_sync = (i == 0);
        oct       = slot_oct(pos / 8);
        if (is_ds1 && i == 0) line_data = fill | frm[0];
        else line_data = oct[7 - pos % 8];
        #80 line_clk = 1'b1;
        #80;
      end
      frm = frm + 8'h01;
    end
  end
endmodule : tcep_line_model

// file: verification/test_tcep_packetizer.sv
// Self-checking bench for the circuit emulation packetizer.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module test_tcep_packetizer
  import tcep_pkg::*;
;
  logic              core_clk, rst_b, port_en, cas_en, ds1, fill;
  tcep_circuit_t     circuit_type_setting;
  logic [31:0]       slot_mask;
  logic [SIZE_W-1:0] pay_size;
  logic              line_clk, line_data, line_sync;
  logic              pkt_valid, pkt_sop, pkt_eop, cfg_err;
  logic [7:0]        pkt_data;
  logic [5:0]        grp_count;
  logic [7:0]        q [$];
  int                failures, total_checks;

  tcep_line_model model_u (.ds1(ds1), .fill(fill), .line_clk(line_clk),
    .line_data(line_data), .line_sync(line_sync));

  tcep_packetizer dut_u (.core_clk(core_clk), .rst_b(rst_b), .line_clk(line_clk),
    .line_data(line_data), .line_sync(line_sync), .port_en(port_en),
    .circuit_type_setting(circuit_type_setting), .cas_en(cas_en), .slot_mask(slot_mask),
    .pay_size(pay_size), .pkt_valid(pkt_valid), .pkt_sop(pkt_sop), .pkt_eop(pkt_eop),
    .pkt_data(pkt_data), .cfg_err(cfg_err), .grp_count(grp_count));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Waits out the old frame when the line format changes so the first packet sees clean frames.
  task automatic setup(input tcep_circuit_t t, input logic c, input logic [31:0] m,
                       input logic [SIZE_W-1:0] s, input logic fl);
    logic d;
    int   n;
    d = (t == unstructured_ds1_type || t == structured_ds1_type);
    n = (d !== ds1) ? 2100 : 4;
    port_en = 1'b0;
    circuit_type_setting = t;
    cas_en = c;
    slot_mask = m;
    pay_size = s;
    fill = fl;
    ds1 = d;
    repeat (n) @(posedge core_clk);
    #1;
    port_en = 1'b1;
  endtask : setup

  // Collects one packet from start to end marker.
  task automatic grab;
    q.delete();
    for (int n = 0; n < 80000; n++) begin
      @(posedge core_clk);
      #1;
      if (pkt_valid === 1'b1 && (pkt_sop === 1'b1 || q.size() > 0)) begin
        q.push_back(pkt_data);
        if (pkt_eop === 1'b1) break;
      end
    end
  endtask : grab

  task automatic check_cfg;
    tcep_circuit_t tt [10];
    logic [31:0]   mm [10];
    int            ss [10];
    logic          ee [10];
    int            gg [10];
    int            seen;
    tt = '{unstructured_ds1_type, structured_ds1_type, unstructured_e1_type,
           unstructured_e1_type, unstructured_e1_type, structured_e1_type, structured_e1_type,
           structured_e1_type, structured_e1_type, structured_e1_type};
    mm = '{0, 32'hffff_ffff, 0, 0, 0, 32'hffff_ffff, 0, 32'h6, 32'h6, 32'h2};
    ss = '{0, 48, 1, 1515, 1514, 31, 4, 5, 1516, 1};
    ee = '{0, 0, 1, 1, 0, 0, 1, 1, 1, 1};
    gg = '{24, 24, 32, 32, 32, 31, 0, 2, 2, 1};
    seen = 0;
    for (int i = 0; i < 10; i++) begin
      setup(tt[i], 1'b0, mm[i], SIZE_W'(ss[i]), 1'b0);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("config error", ee[i], cfg_err)
      `CHK("group count", 6'(gg[i]), grp_count)
    end
    for (int n = 0; n < 2100; n++) begin
      @(posedge core_clk);
      #1;
      if (pkt_valid !== 1'b0) seen++;
    end
    `CHK("output while invalid", 0, seen)
  endtask : check_cfg

  task automatic ds1_unstructured;
    int ones;
    setup(unstructured_ds1_type, 1'b0, 32'h0, 11'h0, 1'b1);
    grab();
    ones = 0;
    foreach (q[k]) ones += $countones(q[k]);
    `CHK("ds1 default length", 192, q.size())
    `CHK("ds1 framing bits", 1'b1, (ones == 7 || ones == 8))
  endtask : ds1_unstructured

  task automatic ds1_structured;
    logic [2:0] f0;
    setup(structured_ds1_type, 1'b0, 32'h0080_0001, 11'h4, 1'b0);
    grab();
    f0 = q[0][7:5];
    `CHK("ds1 group length", 4, q.size())
    for (int k = 0; k < 4; k++) begin
      `CHK("ds1 group octet", {3'(f0 + k / 2), (k % 2) ? 5'h17 : 5'h00}, q[k])
    end
  endtask : ds1_structured

  task automatic e1_unstructured;
    setup(unstructured_e1_type, 1'b0, 32'h0, 11'h0, 1'b0);
    grab();
    `CHK("e1 default length", 256, q.size())
    setup(unstructured_e1_type, 1'b0, 32'h0, 11'h2, 1'b0);
    grab();
    `CHK("e1 minimum length", 2, q.size())
  endtask : e1_unstructured

  task automatic e1_cas;
    logic [4:0] sl [3];
    sl = '{5'h1, 5'h3, 5'h5};
    setup(structured_e1_type, 1'b1, 32'h0000_002a, 11'h30, 1'b0);
    grab();
    `CHK("cas length", 50, q.size())
    for (int k = 0; k < 48; k++) begin
      `CHK("cas slot octet", {3'(k / 3), sl[k % 3]}, q[k])
    end
    `CHK("cas nibbles", 8'h13, q[48])
    `CHK("cas pad", 8'h50, q[49])
  endtask : e1_cas

  initial begin
    #3_000_000;
    failures++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    port_en = 1'b0;
    circuit_type_setting = unstructured_ds1_type;
    cas_en = 1'b0;
    slot_mask = 32'h0;
    pay_size = 11'h0;
    ds1 = 1'b1;
    fill = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    check_cfg();
    e1_unstructured();
    ds1_unstructured();
    ds1_structured();
    e1_cas();
    close_out();
  end
endmodule : test_tcep_packetizer
